// ===== logic/tdm_command_audio_slave.sv
// Purpose: receiver of a multiplexed command and audio serial frame, with daisy chain
// Assumes: link pins are asynchronous; bit clock well below clock_i / 4
// Notes: command-space registers also reachable over AHB-Lite
// How it works
// - five-bit identifier is taken from command bits 28 to 24
// - identifiers follow chain order starting at one
// - a device whose chain input is held high becomes identifier one
// - identifier 0x1f write reaches every device as broadcast
// - identifier zero selects no device
// - command bit 23 high means read, low means write
// - register number is command bits 22 to 16
// - write value is command bits 15 to 8
// - lowest command byte is never driven during a read
// - extended command decodes alike, its bit 31 ignored
// - audio slots are 32 bits msb first, sample in top 24 bits
// - register 23 holds identifier; register 19 flag disables the channels
// - addressed read returns register data in the same command slot
// - input sampled on rising bit clock, output changed on falling
// - data output enabled one bit period before read data
// - chain output high during own last audio channel
// - chain input high means next audio slot is ours
// - device with inactive channels passes chain input to chain output, except after slot 0 of an identifier frame
// - bit 31 set makes the frame identifier assignment only
// - bit 30 set adds an extended slot and removes audio
// - a two-bit frame sync pulse marks the multiplexed format
// - mode entered after two such frames, commands from the next
`timescale 1ns/1ps
module tdm_command_audio_slave
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic bit_clock_i,
    input wire logic frame_sync_i,
    input wire logic frame_data_in_i,
    input wire logic chain_in_i,
    output logic data_out_o,
    output logic data_out_oe_o,
    output logic chain_out_o,
    output logic tdm_mode_o,
    output logic [tdm_slave_pkg::SAMPLE_W-1:0] sample_left_o,
    output logic [tdm_slave_pkg::SAMPLE_W-1:0] sample_right_o,
    input wire logic hsel_i,
    input wire logic [tdm_slave_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [tdm_slave_pkg::DATA_W-1:0] hwdata_i,
    input wire logic hready_i,
    output logic [tdm_slave_pkg::DATA_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    import tdm_slave_pkg::*;

    typedef struct packed {
        logic bclk_s1;
        logic bclk_s2;
        logic bclk_d;
        logic fs_s1;
        logic fs_s2;
        logic fs_prev;
        logic din_s1;
        logic din_s2;
        logic cin_s1;
        logic cin_s2;
        logic [1:0] fs_len;
        logic [1:0] frames;
        logic tdm_mode;
        logic cmd_ok;
        logic [4:0] bit_cnt;
        logic [5:0] slot;
        logic [SLOT_BITS-1:0] shift;
        logic ext_next;
        logic no_audio;
        logic own;
        logic ch;
        logic served;
        logic rd_mine;
        logic rd_on;
        logic [7:0] rd_sh;
        logic dout;
        logic doe;
        logic chain_out;
        logic [4:0] dev_id;
        logic id_valid;
        logic id_frame;
        logic id_seen;
        logic id_drive;
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
        logic [SLOT_BITS-1:0] last_cmd;
        logic [127:0][7:0] regs;
        logic a_act;
        logic a_wr;
        logic [9:0] a_addr;
        logic rd_pend;
        logic [DATA_W-1:0] hrdata;
    } state_t;

    state_t r_reg;
    state_t r_next;

    logic rise;
    logic fall;
    logic frame_start;
    logic fs_fall;
    logic [4:0] pos;
    logic [SLOT_BITS-1:0] word_w;
    logic slot0;
    logic cmd_slot;
    logic active;
    logic slot_end;
    logic id_now;
    logic tdm_wr;
    logic [6:0] w_idx;
    logic [7:0] w_data;
    logic [4:0] w_id;

    // addressed check shared by the command and extended command slots
    function automatic logic hits(input logic [SLOT_BITS-1:0] w, input logic first,
                                  input logic [4:0] id, input logic idv);
        logic [4:0] t;
        t = w[ID_HI:ID_LO];
        hits = !(first && w[ID_ASSIGN_BIT]) && !w[CHAIN_SEL_BIT] && (t != ID_NONE)
            && ((idv && (t == id)) || ((t == ID_BROADCAST) && !w[RW_BIT]));
    endfunction

    function automatic logic [7:0] reg_value(input state_t s, input logic [6:0] idx);
        reg_value = (idx == REG_DEVICE_ID) ? {3'h0, s.dev_id} : s.regs[idx];
    endfunction

    assign rise = r_reg.bclk_s2 & ~r_reg.bclk_d;
    assign fall = ~r_reg.bclk_s2 & r_reg.bclk_d;
    assign frame_start = rise & r_reg.fs_s2 & ~r_reg.fs_prev;
    assign fs_fall = rise & ~r_reg.fs_s2 & r_reg.fs_prev;
    assign pos = frame_start ? 5'h00 : r_reg.bit_cnt;
    assign word_w = frame_start ? {31'h0, r_reg.din_s2} : {r_reg.shift[30:0], r_reg.din_s2};
    assign slot0 = (r_reg.slot == 6'h00) && !frame_start;
    assign cmd_slot = slot0 || r_reg.ext_next;
    assign active = !r_reg.regs[REG_CHANNEL_CTRL][OUTPUT_DISABLE_POS];
    assign slot_end = rise && !frame_start && (pos == SLOT_LAST_POS);
    assign w_idx = word_w[REG_HI:REG_LO];
    assign w_data = word_w[DATA_HI:DATA_LO];
    assign w_id = word_w[ID_HI:ID_LO];
    assign id_now = r_reg.id_frame || (slot0 && r_reg.cmd_ok && word_w[ID_ASSIGN_BIT]);
    // write from a command slot; bit 31 only counts in the first slot
    assign tdm_wr = slot_end && cmd_slot && r_reg.cmd_ok && !word_w[RW_BIT]
        && hits(word_w, slot0, r_reg.dev_id, r_reg.id_valid)
        && (w_idx != REG_DEVICE_ID);

    always_comb
    begin
        r_next = r_reg;
        r_next.bclk_s1 = bit_clock_i;
        r_next.bclk_s2 = r_reg.bclk_s1;
        r_next.bclk_d = r_reg.bclk_s2;
        r_next.fs_s1 = frame_sync_i;
        r_next.fs_s2 = r_reg.fs_s1;
        r_next.din_s1 = frame_data_in_i;
        r_next.din_s2 = r_reg.din_s1;
        r_next.cin_s1 = chain_in_i;
        r_next.cin_s2 = r_reg.cin_s1;
        if (rise)
        begin
            r_next.fs_prev = r_reg.fs_s2;
            r_next.shift = word_w;
            r_next.bit_cnt = pos + 5'h01;
            if (frame_start)
            begin
                r_next.fs_len = 2'h1;
                r_next.slot = 6'h00;
                r_next.cmd_ok = r_reg.tdm_mode;
                r_next.ext_next = 1'b0;
                r_next.no_audio = 1'b0;
                r_next.own = 1'b0;
                r_next.ch = 1'b0;
                r_next.served = 1'b0;
                r_next.rd_mine = 1'b0;
                r_next.rd_on = 1'b0;
                r_next.id_frame = 1'b0;
                r_next.id_seen = 1'b0;
                r_next.id_drive = 1'b0;
            end
            else if (r_reg.fs_s2 && (r_reg.fs_len != 2'h3))
            begin
                r_next.fs_len = r_reg.fs_len + 2'h1;
                if (r_reg.fs_len == SYNC_PULSE_BITS)
                    r_next.cmd_ok = 1'b0;
            end
            if (fs_fall)
            begin
                if (r_reg.fs_len == SYNC_PULSE_BITS)
                begin
                    r_next.frames = (r_reg.frames == FRAMES_TO_ENTER) ? r_reg.frames
                        : r_reg.frames + 2'h1;
                    r_next.tdm_mode = (r_next.frames == FRAMES_TO_ENTER);
                end
                else
                begin
                    r_next.frames = 2'h0;
                    r_next.tdm_mode = 1'b0;
                    r_next.cmd_ok = 1'b0;
                end
            end
            if (!frame_start && (pos == HDR_DONE_POS))
            begin
                r_next.rd_mine = cmd_slot && r_reg.cmd_ok && word_w[0]
                    && hits({word_w[8:0], 23'h0}, slot0, r_reg.dev_id,
                            r_reg.id_valid);
            end
            if (!frame_start && (pos == OE_LEAD_POS))
            begin
                r_next.rd_on = r_reg.rd_mine;
                r_next.rd_sh = 8'h00;
            end
            if (!frame_start && (pos == RD_LOAD_POS) && r_reg.rd_on)
                r_next.rd_sh = reg_value(r_reg, word_w[6:0]);
            if (!frame_start && (pos == RD_END_POS))
                r_next.rd_on = 1'b0;
            if (slot_end)
            begin
                r_next.slot = r_reg.slot + 6'h01;
                r_next.ext_next = 1'b0;
                r_next.id_drive = 1'b0;
                if (cmd_slot)
                begin
                    if (r_reg.cmd_ok && !(slot0 && word_w[ID_ASSIGN_BIT]))
                    begin
                        r_next.ext_next = word_w[EXT_BIT];
                        r_next.no_audio = r_reg.no_audio | word_w[EXT_BIT];
                        if (hits(word_w, slot0, r_reg.dev_id, r_reg.id_valid))
                            r_next.last_cmd = word_w;
                    end
                    if (slot0 && r_reg.cmd_ok && word_w[ID_ASSIGN_BIT])
                        r_next.id_frame = 1'b1;
                    if (tdm_wr)
                        r_next.regs[w_idx] = w_data;
                end
                else if (!r_reg.no_audio && !r_reg.id_frame && r_reg.own)
                begin
                    if (!r_reg.ch)
                    begin
                        r_next.left = word_w[SLOT_BITS-1 -: SAMPLE_W];
                        r_next.ch = 1'b1;
                    end
                    else
                    begin
                        r_next.right = word_w[SLOT_BITS-1 -: SAMPLE_W];
                        r_next.own = 1'b0;
                    end
                end
                if (id_now && r_reg.cin_s2 && !r_reg.id_seen)
                begin
                    r_next.dev_id = r_reg.slot[4:0] + 5'h01;
                    r_next.id_valid = 1'b1;
                    r_next.id_seen = 1'b1;
                    r_next.id_drive = 1'b1;
                end
                if (!id_now && active && !r_reg.served && !r_reg.own && r_reg.cin_s2
                    && !r_next.no_audio && !r_next.ext_next)
                begin
                    r_next.own = 1'b1;
                    r_next.ch = 1'b0;
                    r_next.served = 1'b1;
                end
            end
        end
        if (fall)
        begin
            r_next.doe = r_reg.rd_on;
            r_next.dout = r_reg.rd_on & r_reg.rd_sh[7];
            if (r_reg.rd_on)
                r_next.rd_sh = {r_reg.rd_sh[6:0], 1'b0};
            if (r_reg.id_frame)
            begin
                r_next.chain_out = r_reg.id_drive;
            end
            else if (active)
            begin
                r_next.chain_out = r_reg.own & r_reg.ch;
            end
            else
            begin
                r_next.chain_out = r_reg.cin_s2;
            end
        end
        // bus data phase: a link write in the same cycle wins
        if (r_reg.a_act && r_reg.a_wr && r_reg.a_addr[REGFILE_SEL_BIT] && !tdm_wr
            && (r_reg.a_addr[8:2] != REG_DEVICE_ID))
        begin
            r_next.regs[r_reg.a_addr[8:2]] = hwdata_i[7:0];
        end
        if (r_reg.rd_pend)
        begin
            r_next.rd_pend = 1'b0;
            r_next.hrdata = '0;
            if (r_reg.a_addr[REGFILE_SEL_BIT])
            begin
                r_next.hrdata[7:0] = reg_value(r_reg, r_reg.a_addr[8:2]);
            end
            else
            begin
                unique case ({r_reg.a_addr[9:2], 2'h0})
                    STATUS_OFFSET:
                    begin
                        r_next.hrdata[ST_MODE_POS] = r_reg.tdm_mode;
                        r_next.hrdata[ST_IDV_POS] = r_reg.id_valid;
                        r_next.hrdata[ST_ACTIVE_POS] = active;
                        r_next.hrdata[ST_ID_LO +: 5] = r_reg.dev_id;
                    end
                    LEFT_OFFSET: r_next.hrdata[SAMPLE_W-1:0] = r_reg.left;
                    RIGHT_OFFSET: r_next.hrdata[SAMPLE_W-1:0] = r_reg.right;
                    LAST_CMD_OFFSET: r_next.hrdata = r_reg.last_cmd;
                    default: r_next.hrdata = '0;
                endcase
            end
        end
        r_next.a_act = hsel_i && hready_i && htrans_i[1];
        if (r_next.a_act)
        begin
            r_next.a_wr = hwrite_i;
            r_next.a_addr = haddr_i[9:0];
            r_next.rd_pend = !hwrite_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r_reg <= '0;
            r_reg.dev_id <= ID_RESET;
            r_reg.regs <= {128{REG_RESET}};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign data_out_o = r_reg.dout;
    assign data_out_oe_o = r_reg.doe;
    assign chain_out_o = r_reg.chain_out;
    assign tdm_mode_o = r_reg.tdm_mode;
    assign sample_left_o = r_reg.left;
    assign sample_right_o = r_reg.right;
    assign hrdata_o = r_reg.hrdata;
    assign hreadyout_o = !r_reg.rd_pend;
    assign hresp_o = 1'b0;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence oe_on;
        $rose(r_reg.doe);
    endsequence

    sequence lead_zero;
        !r_reg.dout [*4];
    endsequence

    no_id_zero_a: assert property (tdm_wr |-> (w_id != ID_NONE))
        else $error("write taken with identifier zero");
    chain_sel_a: assert property (tdm_wr |-> !word_w[CHAIN_SEL_BIT])
        else $error("write taken for the other chain");
    wr_store_a: assert property (tdm_wr |=> r_reg.regs[$past(w_idx)] == $past(w_data))
        else $error("written value not stored");
    id_frame_a: assert property ((slot_end && slot0 && word_w[ID_ASSIGN_BIT]) |-> !tdm_wr)
        else $error("assignment frame acted as a write");
    id_first_a: assert property ((slot_end && slot0 && r_reg.cmd_ok && word_w[ID_ASSIGN_BIT]
        && r_reg.cin_s2 && !r_reg.id_seen) |=> (r_reg.dev_id == ID_FIRST))
        else $error("chain head did not take identifier one");
    dout_fall_a: assert property ($changed(r_reg.dout) |-> $past(fall))
        else $error("data output changed off a falling edge");
    sample_rise_a: assert property ($changed(r_reg.shift) |-> $past(rise))
        else $error("input sampled off a rising edge");
    oe_lead_a: assert property (oe_on |-> lead_zero)
        else $error("read data started without a lead bit");
    oe_stop_a: assert property ($fell(r_reg.doe) |->
        (r_reg.bit_cnt == 5'h18 || r_reg.bit_cnt == 5'h01))
        else $error("output enable ran into the low byte");
    oe_mode_a: assert property (r_reg.doe |-> r_reg.cmd_ok)
        else $error("output driven outside an accepted frame");
    cmd_later_a: assert property ($rose(r_reg.cmd_ok) |-> $past(frame_start) && r_reg.tdm_mode)
        else $error("commands accepted before a new frame");
    skip_pass_a: assert property ((fall && !active && !r_reg.id_frame)
        |=> r_reg.chain_out == $past(r_reg.cin_s2))
        else $error("inactive device did not pass chain input");
    last_ch_a: assert property ((fall && active && !r_reg.id_frame)
        |=> r_reg.chain_out == $past(r_reg.own && r_reg.ch))
        else $error("chain output not marking the last channel");
endmodule

// ===== common/tdm_slave_pkg.sv
// Purpose: shared constants for the multiplexed command/audio slave
// Assumes: 32-bit slots, msb first, 32-bit AHB-Lite register bus
// Notes: byte offsets of the bus registers and field positions of a slot
package tdm_slave_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int SLOT_BITS = 32;
    localparam int SAMPLE_W = 24;
    // bus register byte offsets
    localparam logic [9:0] STATUS_OFFSET = 10'h000;
    localparam logic [9:0] LEFT_OFFSET = 10'h004;
    localparam logic [9:0] RIGHT_OFFSET = 10'h008;
    localparam logic [9:0] LAST_CMD_OFFSET = 10'h00c;
    localparam int REGFILE_SEL_BIT = 9;
    // command field positions
    localparam int ID_ASSIGN_BIT = 31;
    localparam int EXT_BIT = 30;
    localparam int CHAIN_SEL_BIT = 29;
    localparam int ID_HI = 28;
    localparam int ID_LO = 24;
    localparam int RW_BIT = 23;
    localparam int REG_HI = 22;
    localparam int REG_LO = 16;
    localparam int DATA_HI = 15;
    localparam int DATA_LO = 8;
    // device identifiers
    localparam logic [4:0] ID_NONE = 5'h00;
    localparam logic [4:0] ID_FIRST = 5'h01;
    localparam logic [4:0] ID_BROADCAST = 5'h1f;
    localparam logic [4:0] ID_RESET = 5'h00;
    // command-space registers
    localparam logic [6:0] REG_CHANNEL_CTRL = 7'h13;
    localparam logic [6:0] REG_DEVICE_ID = 7'h17;
    localparam int OUTPUT_DISABLE_POS = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    // frame format detection
    localparam logic [1:0] SYNC_PULSE_BITS = 2'h2;
    localparam logic [1:0] FRAMES_TO_ENTER = 2'h2;
    // read output timing, in slot bit positions
    localparam logic [4:0] HDR_DONE_POS = 5'h08;
    localparam logic [4:0] OE_LEAD_POS = 5'h0e;
    localparam logic [4:0] RD_LOAD_POS = 5'h0f;
    localparam logic [4:0] RD_END_POS = 5'h17;
    localparam logic [4:0] SLOT_LAST_POS = 5'h1f;
    // status fields
    localparam int ST_MODE_POS = 0;
    localparam int ST_IDV_POS = 1;
    localparam int ST_ACTIVE_POS = 2;
    localparam int ST_ID_LO = 8;
endpackage

// ===== bench/tdm_host_model.sv
// Purpose: host side of the multiplexed link, driven frame by frame
// Assumes: bit clock stands still between frames, 200 ns period inside
// Notes: records enable and read data at each falling edge of slot 0, chain output at bit 16 of each slot
`timescale 1ns/1ps
module tdm_host_model
(
    output logic bit_clock_o,
    output logic frame_sync_o,
    output logic frame_data_o,
    output logic chain_o,
    input wire logic data_out_i,
    input wire logic data_out_oe_i,
    input wire logic chain_out_i
);
    logic [31:0] slot_q [8];
    logic [31:0] oe_vec;
    logic [31:0] do_vec;
    logic [7:0] co_vec;
    initial
    begin
        bit_clock_o = 1'b0;
        frame_sync_o = 1'b0;
        frame_data_o = 1'b0;
        chain_o = 1'b0;
        foreach (slot_q[i]) slot_q[i] = 32'h0;
    end
    // n slots, sync pulse of p bits, upstream chain level by slot
    task automatic frame(input int n, input int p, input logic [7:0] cmask);
        for (int s = 0; s < n; s++)
        begin
            for (int b = 31; b >= 0; b--)
            begin
                frame_sync_o = (s == 0) && (31 - b < p);
                frame_data_o = slot_q[s][b];
                chain_o = cmask[s];
                #100 bit_clock_o = 1'b1;
                #100 bit_clock_o = 1'b0;
                if (s == 0)
                begin
                    oe_vec[b] = data_out_oe_i;
                    do_vec[b] = data_out_i;
                end
                if (b == 16)
                    co_vec[s] = chain_out_i;
            end
        end
        // released line shows the inverse of its last value
        frame_data_o = ~frame_data_o;
        chain_o = 1'b0;
        #1000;
    endtask
endmodule

// ===== bench/testbench.sv
// Purpose: self-checking bench of the multiplexed command/audio slave
// Assumes: host model drives the link, bench drives AHB-Lite
// Notes: random data from a bench lfsr, fixed start value
`timescale 1ns/1ps
module testbench;
    import tdm_slave_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, dout, dout_oe, chain_out, chain_in, tdm_mode;
    logic bclk, fsync, fdata;
    logic [SAMPLE_W-1:0] left, right;
    logic [31:0] rnd = 32'h84a6;
    logic [31:0] rd;
    logic [7:0] dv [5];
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    always #12.5 clock_i = ~clock_i;
    tdm_host_model host (.bit_clock_o(bclk), .frame_sync_o(fsync), .frame_data_o(fdata),
        .chain_o(chain_in), .data_out_i(dout), .data_out_oe_i(dout_oe),
        .chain_out_i(chain_out));
    tdm_command_audio_slave dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .bit_clock_i(bclk), .frame_sync_i(fsync), .frame_data_in_i(fdata),
        .chain_in_i(chain_in), .data_out_o(dout), .data_out_oe_o(dout_oe),
        .chain_out_o(chain_out), .tdm_mode_o(tdm_mode), .sample_left_o(left),
        .sample_right_o(right), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] cmd(input logic [4:0] id, input logic r,
        input logic [6:0] rg, input logic [7:0] d);
        return {3'h0, id, r, rg, d, 8'h00};
    endfunction
    function automatic logic [31:0] ra(input int n);
        return 32'h200 + 32'(4 * n);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clock_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clock_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            end_sim();
        end
    end
    initial
    begin
        logic [4:0] ids [5];
        logic [23:0] s1, s2;
        ids = '{5'h02, ID_BROADCAST, ID_NONE, 5'h03, 5'h02};
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rchk(32'(STATUS_OFFSET), 32'h4);
        check({31'h0, hresp}, 32'h0);
        // broadcast write sent while mode is not yet entered
        host.slot_q[0] = cmd(ID_BROADCAST, 1'b0, 7'h05, 8'haa);
        host.frame(1, 3, 8'h0);
        check({31'h0, tdm_mode}, 32'h0);
        host.frame(1, 2, 8'h0);
        check({31'h0, tdm_mode}, 32'h0);
        host.frame(1, 2, 8'h0);
        check({31'h0, tdm_mode}, 32'h1);
        rchk(ra(5), 32'h0);
        // identifier frame, other bits hold a broadcast write
        host.slot_q[0] = 32'h9f06_5500;
        host.frame(3, 2, 8'h02);
        rchk(STATUS_OFFSET, 32'h0000_0207);
        check({29'h0, host.co_vec[2:0]}, 32'h4);
        rchk(ra(6), 32'h0);
        rchk(ra(23), 32'h2);
        for (int i = 0; i < 5; i++)
        begin
            dv[i] = rnd[7:0];
            rnd = lfsr(rnd);
            host.slot_q[0] = cmd(ids[i], 1'b0, 7'(7 + i), dv[i]) | {2'h0, i == 4, 21'h0, rnd[7:0]};
            host.frame(1, 2, 8'h0);
            rchk(ra(7 + i), (i < 2) ? {24'h0, dv[i]} : 32'h0);
        end
        rnd = lfsr(rnd);
        host.slot_q[0] = cmd(5'h02, 1'b0, 7'h0d, rnd[7:0]) | 32'h4000_0000;
        host.slot_q[1] = cmd(5'h02, 1'b0, 7'h0e, rnd[15:8]) | 32'h8000_0000;
        host.frame(2, 2, 8'h0);
        rchk(ra(13), {24'h0, rnd[7:0]});
        rchk(ra(14), {24'h0, rnd[15:8]});
        for (int j = 0; j < 3; j++)
        begin
            host.slot_q[0] = cmd(j == 1 ? ID_BROADCAST : 5'h02, 1'b1, j == 2 ? 7'h17 : 7'h07, 8'h0);
            host.frame(1, 2, 8'h0);
            check(host.oe_vec, j == 1 ? 32'h0 : 32'h0001_ff00);
            check({23'h0, host.do_vec[16:8]}, j == 1 ? 32'h0
                : (j == 2 ? 32'h2 : {24'h0, dv[0]}));
        end
        rchk(32'(LAST_CMD_OFFSET), cmd(5'h02, 1'b1, 7'h17, 8'h0));
        bus(1'b1, ra(4), rnd);
        rchk(ra(4), {24'h0, rnd[7:0]});
        rchk(32'h0000_0100, 32'h0);
        s1 = rnd[23:0];
        rnd = lfsr(rnd);
        s2 = rnd[23:0] ^ 24'h5a5a5a;
        rnd = lfsr(rnd);
        for (int k = 0; k < 2; k++)
        begin
            host.slot_q[0] = cmd(ID_NONE, 1'b0, 7'h0, 8'h0);
            host.slot_q[1] = {s1 ^ {24{k[0]}}, 8'h0};
            host.slot_q[2] = {s2 ^ {24{k[0]}}, 8'h0};
            host.frame(3, 2, 8'h01);
            check({8'h0, left}, {8'h0, s1});
            check({8'h0, right}, {8'h0, s2});
            check({29'h0, host.co_vec[2:0]}, k == 0 ? 32'h4 : 32'h1);
            if (k == 0)
            begin
                rchk(32'(LEFT_OFFSET), {8'h0, s1});
                rchk(32'(RIGHT_OFFSET), {8'h0, s2});
                host.slot_q[0] = cmd(5'h02, 1'b0, REG_CHANNEL_CTRL, 8'h01);
                host.frame(1, 2, 8'h0);
                rchk(STATUS_OFFSET, 32'h0000_0203);
            end
        end
        // chain input held high: this device heads the chain
        host.slot_q[0] = 32'h8000_0000;
        host.frame(3, 2, 8'h07);
        check({29'h0, host.co_vec[2:0]}, 32'h3);
        rchk(32'(STATUS_OFFSET), 32'h0000_0103);
        end_sim();
    end
endmodule
